//--- rtl/gdp_top.sv
`timescale 1ns/1ps
`include "gdp_cfg.svh"

module gdp_top
  import gdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Drive inputs from the PWM timer
  input wire logic [2:0] high_side_drive_in_i,
  input wire logic [2:0] low_side_drive_in_i,
  // Drain-source comparators and reference disable
  input wire logic [2:0] ls_overvoltage_i,
  input wire logic [2:0] hs_overvoltage_i,
  input wire logic ref_above_disable_i,
  // Supply and bootstrap comparators
  input wire logic supply_above_on_i,
  input wire logic supply_above_off_i,
  input wire logic [2:0] boot_above_on_i,
  input wire logic [2:0] boot_above_off_i,
  // Gate outputs
  output logic [2:0] high_side_gate_out_o,
  output logic [2:0] low_side_gate_out_o,
  // Ready open-drain pin and interrupt
  output logic ready_out_o,
  output logic ready_oe_o,
  output logic irq_o
);

  gdp_top_state_t s_q;
  gdp_top_state_t s_d;

  logic vcc_lock;
  logic [2:0] boot_lock;
  logic prot_en;
  logic [5:0] deg_cond;
  logic [5:0] deg_fire;
  logic [9:0] deg_limit;
  logic acc_wr;
  logic acc_rd_start;
  logic clear_req;
  logic all_in_low;
  logic release_now;
  logic fault_set;
  logic fault_next;
  logic [2:0] hs_want;
  logic [2:0] ls_want;
  logic [3:0] irq_events;
  logic [31:0] rd_mux;

  // Select code to filter length in clock cycles
  function automatic logic [9:0] deg_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: deg_cycles = 10'(`GDP_US_TO_CYC(`GDP_DEG_US_SEL0));
      2'h1: deg_cycles = 10'(`GDP_US_TO_CYC(`GDP_DEG_US_SEL1));
      2'h2: deg_cycles = 10'(`GDP_US_TO_CYC(`GDP_DEG_US_SEL2));
      default: deg_cycles = 10'(`GDP_US_TO_CYC(`GDP_DEG_US_SEL3));
    endcase
  endfunction

  // Gate supply lockout
  gdp_lockout u_vcc_lock (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .above_on_i(supply_above_on_i),
    .above_off_i(supply_above_off_i),
    .locked_o(vcc_lock)
  );

  // One bootstrap lockout per high side, each independent
  for (genvar p = 0; p < 3; p++) begin : g_boot
    gdp_lockout u_boot_lock (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .above_on_i(boot_above_on_i[p]),
      .above_off_i(boot_above_off_i[p]),
      .locked_o(boot_lock[p])
    );
  end

  // Protection enable from the reference pin comparator
  assign prot_en = !ref_above_disable_i;
  assign deg_limit = deg_cycles(s_q.deg_sel);

  // Anomaly conditions only count while the gate is actually on
  for (genvar p = 0; p < 3; p++) begin : g_cond
    assign deg_cond[p] = prot_en && s_q.ls[p] && ls_overvoltage_i[p];
    assign deg_cond[p + 3] = prot_en && s_q.hs[p] && hs_overvoltage_i[p];
  end

  // Six deglitch filters, low sides then high sides
  for (genvar k = 0; k < 6; k++) begin : g_deg
    gdp_deglitch u_deg (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .cond_i(deg_cond[k]),
      .limit_i(deg_limit),
      .fire_o(deg_fire[k])
    );
  end

  // Bus handshake: one wait cycle, then the access completes
  assign acc_wr = avs_write_i && !s_q.waitreq;
  assign acc_rd_start = (avs_read_i || avs_write_i) && s_q.waitreq;
  assign clear_req = acc_wr && (avs_address_i == `GDP_OFS_CLEAR) && avs_byteenable_i[0]
    && (avs_writedata_i[7:0] == `GDP_CLEAR_ALL_ONES);

  // Fault latch: set wins over any release in the same cycle
  assign all_in_low = (high_side_drive_in_i == 3'h0) && (low_side_drive_in_i == 3'h0);
  assign release_now = (s_q.fault && all_in_low
    && (s_q.rel_cnt >= 12'(`GDP_FAULT_RELEASE_CYC - 1))) || clear_req;
  assign fault_set = prot_en && (deg_fire != 6'h00);
  assign fault_next = fault_set || (s_q.fault && !release_now);

  // Interlock, then protection gating
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      hs_want[p] = high_side_drive_in_i[p]
        && (!low_side_drive_in_i[p] || s_q.interlock_disable_dis);
      ls_want[p] = low_side_drive_in_i[p]
        && (!high_side_drive_in_i[p] || s_q.interlock_disable_dis);
    end
  end

  // Read data, sampled when the wait cycle starts
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `GDP_OFS_CTRL: begin
        rd_mux[`GDP_CTRL_DEG_LSB +: 2] = s_q.deg_sel;
        rd_mux[`GDP_CTRL_RDY_EN_BIT] = s_q.rdy_en;
        rd_mux[`GDP_CTRL_INTERLOCK_DISABLE_DIS_BIT] = s_q.interlock_disable_dis;
      end
      `GDP_OFS_STATUS: begin
        rd_mux[`GDP_STAT_FAULT_BIT] = s_q.fault;
        rd_mux[`GDP_STAT_VCC_LOCK_BIT] = vcc_lock;
        rd_mux[`GDP_STAT_BOOT_LSB +: 3] = boot_lock;
        rd_mux[`GDP_STAT_PROT_EN_BIT] = prot_en;
      end
      `GDP_OFS_IRQ_STATUS: begin
        rd_mux[`GDP_IRQ_W - 1:0] = s_q.irq_st;
      end
      `GDP_OFS_IRQ_ENABLE: begin
        rd_mux[`GDP_IRQ_W - 1:0] = s_q.irq_en;
      end
      default: begin
        rd_mux = 32'h0000_0000; // Unmapped and write-only read zero
      end
    endcase
  end

  // Events that feed the interrupt status
  always_comb begin
    irq_events = 4'h0;
    irq_events[`GDP_IRQ_FAULT] = fault_next && !s_q.fault;
    irq_events[`GDP_IRQ_RELEASE] = s_q.fault && !fault_next;
    irq_events[`GDP_IRQ_VCC_LOCK] = vcc_lock && !s_q.vcc_prev;
    irq_events[`GDP_IRQ_BOOT_LOCK] = (boot_lock & ~s_q.boot_prev) != 3'h0;
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.vcc_prev = vcc_lock;
    s_d.boot_prev = boot_lock;

    // Bus handshake
    if (acc_rd_start) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = rd_mux;
    end else begin
      s_d.waitreq = 1'b1;
    end

    // Register writes, low byte carries every field
    if (acc_wr && avs_byteenable_i[0]) begin
      case (avs_address_i)
        `GDP_OFS_CTRL: begin
          s_d.deg_sel = avs_writedata_i[`GDP_CTRL_DEG_LSB +: 2];
          s_d.rdy_en = avs_writedata_i[`GDP_CTRL_RDY_EN_BIT];
          s_d.interlock_disable_dis = avs_writedata_i[`GDP_CTRL_INTERLOCK_DISABLE_DIS_BIT];
        end
        `GDP_OFS_IRQ_CLEAR: begin
          s_d.irq_st = s_q.irq_st & ~avs_writedata_i[`GDP_IRQ_W - 1:0];
        end
        `GDP_OFS_IRQ_ENABLE: begin
          s_d.irq_en = avs_writedata_i[`GDP_IRQ_W - 1:0];
        end
        default: begin
          s_d.irq_en = s_q.irq_en; // Clear handled above, others ignored
        end
      endcase
    end

    // New events win over a clear in the same cycle
    s_d.irq_st = s_d.irq_st | irq_events;
    s_d.irq = (s_d.irq_st & s_d.irq_en) != 4'h0;

    // Release timer runs only while latched with all inputs idle
    if (s_q.fault && all_in_low && !release_now) begin
      s_d.rel_cnt = s_q.rel_cnt + 12'h001;
    end else begin
      s_d.rel_cnt = 12'h000;
    end
    s_d.fault = fault_next;

    // Gates: fault and supply lockout drop all six; bootstrap only its own
    for (int p = 0; p < 3; p++) begin
      if (fault_next || vcc_lock) begin
        s_d.hs[p] = 1'b0;
        s_d.ls[p] = 1'b0;
      end else begin
        s_d.hs[p] = hs_want[p] && !boot_lock[p];
        s_d.ls[p] = ls_want[p];
      end
    end

    // Ready pulled low in supply lockout only if enabled
    s_d.ready_oe = vcc_lock && s_q.rdy_en;
  end

  // Registered state; gates start off, supplies locked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.deg_sel <= `GDP_DEG_SEL_RESET;
      s_q.vcc_prev <= 1'b1;
      s_q.boot_prev <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, except ready_out_o tied low
  assign high_side_gate_out_o = s_q.hs;
  assign low_side_gate_out_o = s_q.ls;
  assign ready_out_o = 1'b0; // Open drain only ever pulls low
  assign ready_oe_o = s_q.ready_oe;
  assign irq_o = s_q.irq;
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;

endmodule // gdp_top

//--- include/gdp_cfg.svh
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH

// Clock rate and time conversion
`define GDP_CLK_MHZ 100
`define GDP_US_TO_CYC(us) ((us) * `GDP_CLK_MHZ)

// Deglitch times in microseconds, by select code
`define GDP_DEG_US_SEL0 6
`define GDP_DEG_US_SEL1 4
`define GDP_DEG_US_SEL2 3
`define GDP_DEG_US_SEL3 2
`define GDP_DEG_CNT_W 10

// Fault release: all drive inputs low for this long
`define GDP_FAULT_RELEASE_US 20
`define GDP_FAULT_RELEASE_CYC `GDP_US_TO_CYC(`GDP_FAULT_RELEASE_US)
`define GDP_REL_CNT_W 12

// Register byte offsets
`define GDP_ADDR_W 5
`define GDP_OFS_CTRL 5'h00
`define GDP_OFS_STATUS 5'h04
`define GDP_OFS_CLEAR 5'h08
`define GDP_OFS_IRQ_STATUS 5'h0C
`define GDP_OFS_IRQ_CLEAR 5'h10
`define GDP_OFS_IRQ_ENABLE 5'h14

// Control fields and reset values
`define GDP_CTRL_DEG_LSB 0
`define GDP_CTRL_RDY_EN_BIT 2
`define GDP_CTRL_INTERLOCK_DISABLE_DIS_BIT 3
`define GDP_DEG_SEL_RESET 2'h0
`define GDP_CLEAR_ALL_ONES 8'hFF

// Status fields
`define GDP_STAT_FAULT_BIT 0
`define GDP_STAT_VCC_LOCK_BIT 1
`define GDP_STAT_BOOT_LSB 2
`define GDP_STAT_PROT_EN_BIT 5

// Interrupt event bits
`define GDP_IRQ_W 4
`define GDP_IRQ_FAULT 0
`define GDP_IRQ_RELEASE 1
`define GDP_IRQ_VCC_LOCK 2
`define GDP_IRQ_BOOT_LOCK 3

`endif

//--- include/gdp_pkg.sv
package gdp_pkg;

  typedef enum logic {
    GDP_LOCKED,
    GDP_RUNNING
  } gdp_lock_mode_t;

  typedef struct packed {
    gdp_lock_mode_t mode;
    logic locked;
  } gdp_lock_state_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic fire;
  } gdp_deg_state_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
    logic fault;
    logic [11:0] rel_cnt;
    logic [1:0] deg_sel;
    logic rdy_en;
    logic interlock_disable_dis;
    logic [3:0] irq_st;
    logic [3:0] irq_en;
    logic irq;
    logic ready_oe;
    logic waitreq;
    logic [31:0] rdata;
    logic vcc_prev;
    logic [2:0] boot_prev;
  } gdp_top_state_t;

endpackage

//--- rtl/gdp_deglitch.sv
`timescale 1ns/1ps
`include "gdp_cfg.svh"

module gdp_deglitch
  import gdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Condition and filter length
  input wire logic cond_i,
  input wire logic [9:0] limit_i,
  // Filtered result
  output logic fire_o
);

  gdp_deg_state_t s_q;
  gdp_deg_state_t s_d;

  // Count while the condition holds; any gap restarts the filter
  always_comb begin
    s_d = s_q;
    if (!cond_i) begin
      s_d.cnt = '0;
      s_d.fire = 1'b0;
    end else if (s_q.cnt >= limit_i) begin
      s_d.fire = 1'b1; // Held longer than the limit
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end

  // Cleared by device reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fire_o = s_q.fire;

endmodule // gdp_deglitch

//--- rtl/gdp_lockout.sv
`timescale 1ns/1ps

module gdp_lockout
  import gdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Comparator levels: above turn-on, above turn-on minus hysteresis
  input wire logic above_on_i,
  input wire logic above_off_i,
  // Lockout active
  output logic locked_o
);

  gdp_lock_state_t s_q;
  gdp_lock_state_t s_d;

  // Hysteresis: leave on the upper threshold, re-enter on the lower
  always_comb begin
    s_d = s_q;
    case (s_q.mode)
      GDP_LOCKED: begin
        if (above_on_i) begin
          s_d.mode = GDP_RUNNING;
        end
      end
      GDP_RUNNING: begin
        if (!above_off_i) begin
          s_d.mode = GDP_LOCKED;
        end
      end
      default: begin
        s_d.mode = GDP_LOCKED;
      end
    endcase
    s_d.locked = (s_d.mode == GDP_LOCKED);
  end

  // Supplies count as low until proven otherwise
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{mode: GDP_LOCKED, locked: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign locked_o = s_q.locked;

endmodule // gdp_lockout

//--- tb/gdp_monitor.sv
`timescale 1ns/1ps

module gdp_monitor
  import gdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched inputs
  input wire logic [2:0] high_side_drive_in_i,
  input wire logic [2:0] low_side_drive_in_i,
  input wire logic [2:0] ls_overvoltage_i,
  input wire logic [2:0] hs_overvoltage_i,
  input wire logic ref_above_disable_i,
  input wire logic supply_above_off_i,
  input wire logic [2:0] boot_above_off_i,
  // Watched outputs
  input wire logic avs_waitrequest_o,
  input wire logic [2:0] high_side_gate_out_o,
  input wire logic [2:0] low_side_gate_out_o,
  input wire logic ready_out_o,
  input wire logic ready_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic cond;
  // Raw fault condition run length; saturates so it never wraps
  assign cond = !ref_above_disable_i &&
    (|((low_side_gate_out_o & ls_overvoltage_i) | (high_side_gate_out_o & hs_overvoltage_i)));
  assign cnt_d = !cond ? 10'h000 : (cnt_q == 10'h3FF) ? cnt_q : cnt_q + 10'h001;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  a_hs_follow: assert property ((high_side_gate_out_o & ~$past(high_side_drive_in_i)) == 3'h0)
    else $error("high gate on without drive");
  a_ls_follow: assert property ((low_side_gate_out_o & ~$past(low_side_drive_in_i)) == 3'h0)
    else $error("low gate on without drive");
  // Lockout flop then gate flop: gates drop two edges after the comparator falls
  a_supply_lock: assert property (!supply_above_off_i |-> ##2
    (high_side_gate_out_o | low_side_gate_out_o) == 3'h0)
    else $error("gate on during supply lockout");
  a_boot_lock: assert property ((high_side_gate_out_o & ~$past(boot_above_off_i, 2)) == 3'h0)
    else $error("high gate on during bootstrap lockout");
  a_ready_gates: assert property (ready_oe_o |-> (high_side_gate_out_o | low_side_gate_out_o) == 3'h0)
    else $error("ready pulled without lockout");
  a_ready_level: assert property (ready_out_o == 1'b0)
    else $error("ready data not low");
  a_fault_bound: assert property (cnt_q <= 10'h25D)
    else $error("overvoltage held too long without trip");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  // Main scenarios reached
  c_long_cond: cover property (cnt_q == 10'h0C8);
  c_ready: cover property (ready_oe_o);
  c_bus: cover property (!avs_waitrequest_o);
endmodule // gdp_monitor

bind gdp_top gdp_monitor i_gdp_monitor (.*);

//--- tb/gdp_pwm_model.sv
`timescale 1ns/1ps

module gdp_pwm_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Bench override of the timer outputs
  input wire logic ovr_i,
  input wire logic [2:0] ovr_hs_i,
  input wire logic [2:0] ovr_ls_i,
  // Drive outputs
  output logic [2:0] hs_o,
  output logic [2:0] ls_o
);
  logic [7:0] cnt_q;
  logic run_q;
  // Period counter; run starts after one full charge period
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      run_q <= run_q | (cnt_q == 8'hFF);
    end
  end
  // Low sides only until charged low side each period, gap as deadtime
  always_comb begin
    hs_o = (run_q && cnt_q < 8'h78) ? 3'h7 : 3'h0;
    ls_o = (!run_q || cnt_q >= 8'h88) ? 3'h7 : 3'h0;
    if (ovr_i) begin
      hs_o = ovr_hs_i;
      ls_o = ovr_ls_i;
    end
  end
endmodule // gdp_pwm_model

//--- tb/gdp_top_tb_top.sv
`timescale 1ns/1ps
`include "gdp_cfg.svh"

module gdp_top_tb_top import gdp_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rd = 1'b0, wr = 1'b0, ref_dis = 1'b0, son = 1'b1, soff = 1'b1, ovr = 1'b0, wreq, roe, rout, irq;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000, seed = 32'h0001_1439, rq, rdat, rv;
  logic [2:0] lov = 3'h0, hov = 3'h0, bon = 3'h7, boff = 3'h7, ohs = 3'h0, ols = 3'h0, hin, lin, hout, lout;
  int fail_count = 0, checks_done = 0, cyc = 0, k;

  // Timer model and design
  gdp_pwm_model i_gdp_pwm_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .ovr_i(ovr), .ovr_hs_i(ohs),
    .ovr_ls_i(ols), .hs_o(hin), .ls_o(lin));
  gdp_top i_gdp_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rq),
    .avs_waitrequest_o(wreq), .high_side_drive_in_i(hin), .low_side_drive_in_i(lin),
    .ls_overvoltage_i(lov), .hs_overvoltage_i(hov), .ref_above_disable_i(ref_dis),
    .supply_above_on_i(son), .supply_above_off_i(soff), .boot_above_on_i(bon), .boot_above_off_i(boff),
    .high_side_gate_out_o(hout), .low_side_gate_out_o(lout), .ready_out_o(rout), .ready_oe_o(roe),
    .irq_o(irq));

  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected gate of side a with opposite side b
  function automatic logic [2:0] exp_gate(input logic [2:0] a, b, input logic dis);
    return dis ? a : (a & ~b);
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Avalon master: holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic gate_chk(input logic [2:0] h, l, eh, el);
    @(posedge clk_i);
    ohs <= h;
    ols <= l;
    repeat (2) @(posedge clk_i);
    chk(hout, eh);
    chk(lout, el);
  endtask

  // Trip at one deglitch code, then release
  task automatic deg(input int s);
    logic [2:0] h, l;
    int n;
    n = 100 * (s == 0 ? 6 : s == 1 ? 4 : s == 2 ? 3 : 2);
    h = {2'b00, s[0]};
    l = {2'b00, !s[0]};
    bus(1'b1, `GDP_OFS_CTRL, 32'(s));
    gate_chk(h, l, h, l);
    {hov[0], lov[0]} <= {s[0], !s[0]};
    repeat (n - 10) @(posedge clk_i);
    {hov[0], lov[0]} <= 2'b00;
    repeat (3) @(posedge clk_i);
    chk(hout | lout, 3'h1);
    {hov[0], lov[0]} <= {s[0], !s[0]};
    k = 0;
    while ((hout | lout) !== 3'h0 && k < 700) begin
      @(posedge clk_i);
      k++;
    end
    {hov[0], lov[0]} <= 2'b00;
    chk(k >= n && k <= n + 5, 1'b1);
    repeat (5) @(posedge clk_i);
    chk(hout | lout, 3'h0);
    chk(irq, 1'b1);
    bus(1'b0, `GDP_OFS_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0021);
    bus(1'b0, `GDP_OFS_IRQ_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0009);
    if (s < 3) begin
      bus(1'b1, `GDP_OFS_CLEAR, 32'h0000_00FF);
    end else begin
      ohs <= 3'h0;
      ols <= 3'h0;
      repeat (2010) @(posedge clk_i);
    end
    bus(1'b1, `GDP_OFS_IRQ_CLEAR, 32'h0000_0003);
    gate_chk(h, l, h, l);
    chk(irq, 1'b0);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk(lout, 3'h7);
    bus(1'b0, `GDP_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    bus(1'b0, 5'h1C, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    repeat (300) @(posedge clk_i);
    ovr <= 1'b1;
    // Random and corner drive patterns, interlock on then off
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, `GDP_OFS_CTRL, 32'(d * 8));
      gate_chk(3'h7, 3'h7, {3{d[0]}}, {3{d[0]}});
      repeat (12) begin
        rv = xs();
        gate_chk(rv[2:0], rv[5:3], exp_gate(rv[2:0], rv[5:3], d[0]), exp_gate(rv[5:3], rv[2:0], d[0]));
      end
    end
    bus(1'b1, `GDP_OFS_CTRL, 32'h0000_0004);
    bus(1'b0, `GDP_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0004);
    bon <= 3'h5;
    boff <= 3'h5;
    gate_chk(3'h7, 3'h0, 3'h5, 3'h0);
    bus(1'b0, `GDP_OFS_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0028);
    bon <= 3'h7;
    boff <= 3'h7;
    gate_chk(3'h7, 3'h0, 3'h7, 3'h0);
    son <= 1'b0;
    soff <= 1'b0;
    gate_chk(3'h0, 3'h7, 3'h0, 3'h0);
    chk(roe, 1'b1);
    soff <= 1'b1;
    gate_chk(3'h0, 3'h7, 3'h0, 3'h0);
    bus(1'b1, `GDP_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk(roe, 1'b0);
    son <= 1'b1;
    gate_chk(3'h0, 3'h7, 3'h0, 3'h7);
    // Lockout event: masked, enabled, cleared
    chk(irq, 1'b0);
    bus(1'b1, `GDP_OFS_IRQ_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    bus(1'b1, `GDP_OFS_IRQ_CLEAR, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    bus(1'b1, `GDP_OFS_IRQ_ENABLE, 32'h0000_0001);
    ref_dis <= 1'b1;
    gate_chk(3'h0, 3'h1, 3'h0, 3'h1);
    lov <= 3'h1;
    repeat (700) @(posedge clk_i);
    chk(lout, 3'h1);
    lov <= 3'h0;
    ref_dis <= 1'b0;
    for (int s = 0; s < 4; s++) deg(s);
    // Fault latch cleared by a reset in mid-run
    hov <= 3'h1;
    repeat (210) @(posedge clk_i);
    chk(hout, 3'h0);
    reset_n_i <= 1'b0;
    hov <= 3'h0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    gate_chk(3'h1, 3'h0, 3'h1, 3'h0);
    give_verdict();
  end
endmodule // gdp_top_tb_top
